// *** rtl/mpra_top.sv ***
// Multiprocessor resource arbiter: chain interface and request sequencer
`timescale 1ns/1ps

module mpra_top (
    input  wire logic               CORE_CLK,
    input  wire logic               RESET,
    // Command port
    input  wire logic               CMD_VALID,
    input  wire mpra_pkg::mpra_cmd_t CMD,
    output logic                    CMD_READY,
    output logic                    RES_VALID,
    output mpra_pkg::mpra_res_t     RES,
    // Daisy chain
    input  wire logic               CHAIN_REQUEST_N_I,
    output logic                    CHAIN_REQUEST_N_O,
    output logic                    CHAIN_REQUEST_N_OE,
    input  wire logic               CHAIN_BUSY_N,
    input  wire logic               CHAIN_ACCEPT_IN_N,
    output logic                    CHAIN_ACCEPT_OUT_N
);

    // ************************************************************
    // Declarations
    // ************************************************************
    mpra_pkg::mpra_state_t          state_r;
    logic                           req_r;
    logic [mpra_pkg::REG_W-1:0]     cnt_r;
    logic [mpra_pkg::PRE_W-1:0]     pre_r;
    logic                           tick;
    logic [2:0]                     sync_d;
    logic [2:0]                     sync_q;
    logic                           busy_s_n;
    logic                           acc_s_n;
    logic                           mux_n;
    logic                           take;
    logic                           start_req;
    logic                           busy_abort;
    logic                           final_test;
    logic                           won;
    mpra_pkg::mpra_res_t            res_r;
    logic                           res_vld_r;

    // ************************************************************
    // Chain input synchronisation
    // ************************************************************

    // Each pin gets its own flops; gating raw async pins could glitch
    assign sync_d = {CHAIN_BUSY_N, CHAIN_REQUEST_N_I, CHAIN_ACCEPT_IN_N};

    mpra_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk (CORE_CLK),
        .rst (RESET),
        .d   (sync_d),
        .q   (sync_q)
    );

    // Busy is the request wire as well, so either being low counts
    assign busy_s_n = sync_q[2] & sync_q[1];
    assign acc_s_n  = sync_q[0];

    // ************************************************************
    // Chain glue
    // ************************************************************

    // Accept out uses the raw input so the chain ripples without clock delay
    mpra_glue u_pass (
        .req_active   (req_r),
        .busy_n       (busy_s_n),
        .accept_in_n  (CHAIN_ACCEPT_IN_N),
        .mux_n        (),
        .accept_out_n (CHAIN_ACCEPT_OUT_N)
    );

    // Processor-side mux works on the synchronised copies
    mpra_glue u_mux (
        .req_active   (req_r),
        .busy_n       (busy_s_n),
        .accept_in_n  (acc_s_n),
        .mux_n        (mux_n),
        .accept_out_n ()
    );

    // Open drain: only ever pull low, enable while requesting
    assign CHAIN_REQUEST_N_O  = mpra_pkg::LINE_LOW;
    assign CHAIN_REQUEST_N_OE = req_r;

    // ************************************************************
    // Command decode
    // ************************************************************

    // No new command while the settle loop runs
    assign CMD_READY  = (state_r == mpra_pkg::MPRA_ST_IDLE);
    assign take       = CMD_VALID && CMD_READY;
    // Input still shows the busy path here since the request is not yet out
    assign busy_abort = take && CMD.op == mpra_pkg::MPRA_OP_REQUEST && !mux_n;
    assign start_req  = take && CMD.op == mpra_pkg::MPRA_OP_REQUEST && mux_n;
    assign final_test = (state_r == mpra_pkg::MPRA_ST_SETTLE) && tick
                        && (cnt_r == '0);
    assign won        = final_test && !mux_n;

    // ************************************************************
    // Settle prescaler
    // ************************************************************

    // One step every seven clocks; also covers the synchroniser delay
    assign tick = (pre_r == mpra_pkg::PRE_LAST);

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pre_r <= mpra_pkg::PRE_ZERO;
        end else if (state_r != mpra_pkg::MPRA_ST_SETTLE || tick) begin
            pre_r <= mpra_pkg::PRE_ZERO;
        end else begin
            pre_r <= pre_r + 3'h1;
        end
    end

    // ************************************************************
    // Settle counter
    // ************************************************************

    // Loaded at request time, stepped down on each prescaler tick
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            cnt_r <= '0;
        end else if (start_req) begin
            cnt_r <= CMD.settle;
        end else if (state_r == mpra_pkg::MPRA_ST_SETTLE && tick && cnt_r != '0) begin
            cnt_r <= cnt_r - 16'h1;
        end
    end

    // ************************************************************
    // Sequencer state
    // ************************************************************

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            state_r <= mpra_pkg::MPRA_ST_IDLE;
        end else begin
            case (state_r)
                mpra_pkg::MPRA_ST_IDLE: begin
                    if (start_req) begin
                        state_r <= mpra_pkg::MPRA_ST_SETTLE;
                    end
                end
                mpra_pkg::MPRA_ST_SETTLE: begin
                    if (final_test) begin
                        state_r <= mpra_pkg::MPRA_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= mpra_pkg::MPRA_ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Request output
    // ************************************************************

    // Set and release work regardless of arbitration, giving a plain port bit
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            req_r <= 1'b0;
        end else if (start_req) begin
            req_r <= 1'b1;
        end else if (take && CMD.op == mpra_pkg::MPRA_OP_SET) begin
            req_r <= 1'b1;
        end else if (take && CMD.op == mpra_pkg::MPRA_OP_RELEASE) begin
            req_r <= 1'b0;
        end else if (final_test && mux_n) begin
            req_r <= 1'b0;
        end
    end

    // ************************************************************
    // Result and flags
    // ************************************************************

    // One result per command; request reports only when finished
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            res_vld_r <= 1'b0;
            res_r     <= '0;
        end else begin
            res_vld_r <= 1'b0;
            if (busy_abort) begin
                res_vld_r                   <= 1'b1;
                res_r                       <= '0;
                res_r.op                    <= mpra_pkg::MPRA_OP_REQUEST;
                res_r.busy                  <= 1'b1;
                {res_r.flag_s, res_r.flag_z} <= mpra_pkg::SZ_BUSY;
                res_r.level                 <= mux_n;
                res_r.req                   <= 1'b0;
            end else if (final_test) begin
                res_vld_r                   <= 1'b1;
                res_r                       <= '0;
                res_r.op                    <= mpra_pkg::MPRA_OP_REQUEST;
                res_r.granted               <= won;
                res_r.failed                <= !won;
                {res_r.flag_s, res_r.flag_z} <= won ? mpra_pkg::SZ_GRANTED
                                                    : mpra_pkg::SZ_FAILED;
                res_r.level                 <= mux_n;
                res_r.req                   <= won;
            end else if (take && CMD.op != mpra_pkg::MPRA_OP_REQUEST) begin
                res_vld_r <= 1'b1;
                res_r     <= '0;
                res_r.op  <= CMD.op;
                res_r.req <= (CMD.op == mpra_pkg::MPRA_OP_SET) ? 1'b1
                           : (CMD.op == mpra_pkg::MPRA_OP_RELEASE) ? 1'b0 : req_r;
                if (CMD.op == mpra_pkg::MPRA_OP_TEST) begin
                    // Sign mirrors the input level, zero its inverse
                    res_r.level  <= mux_n;
                    res_r.flag_s <= mux_n;
                    res_r.flag_z <= !mux_n;
                end else begin
                    {res_r.flag_s, res_r.flag_z} <= mpra_pkg::SZ_NONE;
                end
            end
        end
    end

    assign RES_VALID = res_vld_r;
    assign RES       = res_r;

    // ************************************************************
    // Assertions
    // ************************************************************

    a_accept_block: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        req_r |-> CHAIN_ACCEPT_OUT_N)
        else $error("accept out not held high while requesting");

    a_accept_pass: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        !req_r |-> (CHAIN_ACCEPT_OUT_N == CHAIN_ACCEPT_IN_N))
        else $error("accept out does not follow accept in");

    a_drive_od: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (CHAIN_REQUEST_N_OE == req_r) && !CHAIN_REQUEST_N_O)
        else $error("request line not driven open drain");

    a_busy_abort: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (take && CMD.op == mpra_pkg::MPRA_OP_REQUEST && !busy_s_n && !req_r)
        |=> (!req_r && RES_VALID && RES.busy && state_r == mpra_pkg::MPRA_ST_IDLE))
        else $error("request made while resource busy");

    a_req_start: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (take && CMD.op == mpra_pkg::MPRA_OP_REQUEST && busy_s_n && !req_r)
        |=> (req_r && CHAIN_REQUEST_N_OE && state_r == mpra_pkg::MPRA_ST_SETTLE))
        else $error("free resource did not start a request");

    a_prescale_gap: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (state_r == mpra_pkg::MPRA_ST_SETTLE && tick && cnt_r != '0)
        |=> (!tick)[*6] ##1 tick)
        else $error("settle step not at one seventh of clock");

    a_settle_zero: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (state_r == mpra_pkg::MPRA_ST_SETTLE && tick && cnt_r != '0)
        |=> (cnt_r == $past(cnt_r) - 16'h1) && state_r == mpra_pkg::MPRA_ST_SETTLE)
        else $error("settle loop left early or count wrong");

    a_fail_drop: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (final_test && acc_s_n) |=> (!req_r && RES_VALID && RES.failed))
        else $error("request not withdrawn on failure");

    a_grant_flag: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (RES_VALID && RES.op == mpra_pkg::MPRA_OP_REQUEST)
        |-> ({RES.flag_s, RES.flag_z} == (RES.busy ? mpra_pkg::SZ_BUSY
             : RES.granted ? mpra_pkg::SZ_GRANTED : mpra_pkg::SZ_FAILED))
            && (RES.granted == req_r))
        else $error("outcome flags do not match request result");

    a_set_release: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (take && CMD.op == mpra_pkg::MPRA_OP_SET) |=> req_r ##1 (req_r || $past(take)))
        else $error("set command did not assert request");

    a_release_cmd: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (take && CMD.op == mpra_pkg::MPRA_OP_RELEASE) |=> (!req_r && RES_VALID))
        else $error("release command did not drop request");

    a_test_flags: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (take && CMD.op == mpra_pkg::MPRA_OP_TEST)
        |=> (RES_VALID && RES.level == $past(mux_n) && RES.flag_s == RES.level
             && RES.flag_z == !RES.level))
        else $error("test command flags do not follow input");

    a_grant_keep: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (final_test && !acc_s_n) |=> (req_r && RES_VALID && RES.granted && CHAIN_ACCEPT_OUT_N))
        else $error("granted request not kept");

    a_ready_settle: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (state_r == mpra_pkg::MPRA_ST_SETTLE) |-> !CMD_READY)
        else $error("command accepted during settle loop");

    a_settle_req: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (state_r == mpra_pkg::MPRA_ST_SETTLE) |-> (req_r && CHAIN_REQUEST_N_OE))
        else $error("accept path examined without request out");

    a_busy_merge: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (!CHAIN_REQUEST_N_I)[*3] |-> !busy_s_n)
        else $error("held request line not seen as busy");

    a_final_level: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        final_test |=> (RES.level == $past(acc_s_n) && RES.failed == $past(acc_s_n)))
        else $error("final test result does not follow accept");

endmodule : mpra_top

// *** rtl/mpra_pkg.sv ***
// Shared types and constants of the multiprocessor resource arbiter
package mpra_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int          REG_W     = 16;   // Settle count register
    localparam int          DIV_RATIO = 7;    // Settle count steps at clock / 7
    localparam int          PRE_W     = 3;
    localparam logic [2:0]  PRE_LAST  = 3'(DIV_RATIO - 1);
    localparam logic [2:0]  PRE_ZERO  = 3'h0;
    localparam int          SYNC_STAGES = 2;

    // Flag outcome codes, ordered {sign, zero}
    localparam logic [1:0]  SZ_BUSY    = 2'h1;
    localparam logic [1:0]  SZ_GRANTED = 2'h2;
    localparam logic [1:0]  SZ_FAILED  = 2'h0;
    localparam logic [1:0]  SZ_NONE    = 2'h0;

    // Open-drain low level of the shared request line
    localparam logic        LINE_LOW = 1'b0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MPRA_OP_REQUEST = 2'h0,   // request_resource_instr
        MPRA_OP_SET     = 2'h1,   // assert_request_instr
        MPRA_OP_TEST    = 2'h2,   // test_arbit_input_instr
        MPRA_OP_RELEASE = 2'h3    // release_request_instr
    } mpra_op_t;

    typedef enum logic [1:0] {
        MPRA_ST_IDLE   = 2'h0,
        MPRA_ST_SETTLE = 2'h1
    } mpra_state_t;

    typedef struct packed {
        mpra_op_t          op;
        logic [REG_W-1:0]  settle;   // Loaded into the settle counter
    } mpra_cmd_t;

    typedef struct packed {
        mpra_op_t  op;
        logic      busy;
        logic      granted;
        logic      failed;
        logic      flag_s;
        logic      flag_z;
        logic      level;    // Multiprocessor input at the deciding test
        logic      req;      // Request output state after the command
    } mpra_res_t;

endpackage : mpra_pkg

// *** rtl/mpra_sync.sv ***
// Two-flop synchroniser for the chain inputs
`timescale 1ns/1ps

module mpra_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // ************************************************************
    // Synchroniser
    // ************************************************************

    // Idle chain lines are high, so reset to high
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '1;
            q      <= '1;
        end else begin
            meta_r <= d;
            q      <= meta_r;  // First stage feeds nothing else
        end
    end

endmodule : mpra_sync

// *** rtl/mpra_glue.sv ***
// Chain glue: input mux and accept pass-through gate
`timescale 1ns/1ps

module mpra_glue (
    input  wire logic req_active,
    input  wire logic busy_n,
    input  wire logic accept_in_n,
    output logic      mux_n,
    output logic      accept_out_n
);

    // ************************************************************
    // Routing
    // ************************************************************

    // Busy path before the request, accept path after it
    assign mux_n        = req_active ? accept_in_n : busy_n;
    // Requesting stage blocks the accept from going further down
    assign accept_out_n = req_active ? 1'b1 : accept_in_n;

endmodule : mpra_glue

// *** tb/mpra_chain_model.sv ***
// Behavioural model of the neighbouring processors on the arbitration chain
`timescale 1ns/1ps

module mpra_chain_model (
    input  wire logic clk,
    input  wire logic dut_o,
    input  wire logic dut_oe,
    input  wire logic upper_req,
    input  wire logic lower_req,
    input  wire logic slow,
    output logic      wire_n,
    output logic      busy_n,
    output logic      accept_in_n
);

    // ************************************************************
    // Shared wire and accept ripple
    // ************************************************************
    logic [23:0] ripple_r = 24'hFFFFFF;   // Idle chain: accept high
    logic        grant_n;

    // Open-drain wire with pull-up; any stage may pull it low
    assign wire_n = ~((dut_oe && (dut_o == 1'h0)) || upper_req || lower_req);
    // Every stage sees the shared wire as its busy status
    assign busy_n = wire_n;
    // A requesting higher stage keeps the accept for itself
    assign grant_n = wire_n | upper_req;

    // Gate delay of the chain; slow mode mimics a long chain above us
    always_ff @(posedge clk) begin
        ripple_r <= {ripple_r[22:0], grant_n};
    end
    assign accept_in_n = slow ? ripple_r[23] : ripple_r[0];

endmodule : mpra_chain_model

// *** tb/mpra_top_test.sv ***
// Self-checking testbench of the multiprocessor resource arbiter
`timescale 1ns/1ps

module mpra_top_test;

    // ************************************************************
    // Signals
    // ************************************************************
    typedef struct {
        mpra_pkg::mpra_op_t op;
        logic               low;     // Lower stage holds the wire
        logic [5:0]         exp;     // {busy,granted,failed,s,z,req}
        int                 lat;
    } mpra_row_t;

    logic                core_clk;
    logic                reset;
    logic                cmd_valid;
    mpra_pkg::mpra_cmd_t cmd;
    logic                cmd_ready;
    logic                res_valid;
    mpra_pkg::mpra_res_t res;
    logic                req_o;
    logic                req_oe;
    logic                wire_n;
    logic                busy_n;
    logic                acc_in_n;
    logic                acc_out_n;
    logic                upper_req;
    logic                lower_req;
    logic                slow;
    int                  n_fail;
    int                  num_checks;
    int                  lat;
    mpra_row_t           rows [10];

    mpra_top u_dut (
        .CORE_CLK          (core_clk),
        .RESET             (reset),
        .CMD_VALID         (cmd_valid),
        .CMD               (cmd),
        .CMD_READY         (cmd_ready),
        .RES_VALID         (res_valid),
        .RES               (res),
        .CHAIN_REQUEST_N_I (wire_n),
        .CHAIN_REQUEST_N_O (req_o),
        .CHAIN_REQUEST_N_OE(req_oe),
        .CHAIN_BUSY_N      (busy_n),
        .CHAIN_ACCEPT_IN_N (acc_in_n),
        .CHAIN_ACCEPT_OUT_N(acc_out_n)
    );

    mpra_chain_model u_chain (
        .clk        (core_clk),
        .dut_o      (req_o),
        .dut_oe     (req_oe),
        .upper_req  (upper_req),
        .lower_req  (lower_req),
        .slow       (slow),
        .wire_n     (wire_n),
        .busy_n     (busy_n),
        .accept_in_n(acc_in_n)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    // Issue one command; lat counts edges from take to visible result
    task automatic run_cmd(input mpra_pkg::mpra_op_t op, input logic [15:0] settle,
                           input logic up);
        @(negedge core_clk);
        cmd_valid = 1'h1;
        cmd.op = op;
        cmd.settle = settle;
        upper_req = up;
        lat = 0;
        while (cmd_ready !== 1'h1 && lat < 2000) begin
            @(negedge core_clk);
            lat++;
        end
        @(negedge core_clk);
        cmd_valid = 1'h0;
        // A started request holds the port busy until its result
        check(32'(cmd_ready), 32'(op != mpra_pkg::MPRA_OP_REQUEST || res_valid), "ready");
        lat = 1;
        while (res_valid !== 1'h1 && lat < 1000) begin
            @(negedge core_clk);
            lat++;
        end
        check(32'(res_valid), 32'h1, "result seen");
    endtask : run_cmd

    // Compare outcome flags, latency and the open-drain enable
    task automatic expect_res(input logic [5:0] exp, input int elat);
        check(32'({res.busy, res.granted, res.failed, res.flag_s, res.flag_z, res.req}),
              32'(exp), "outcome");
        check(32'(lat), 32'(elat), "latency");
        check(32'(res.level), 32'(exp[3] | (exp[2] & ~exp[4])), "input level");
        check(32'(req_oe), 32'(exp[0]), "request enable");
        if (req_oe === 1'h1) check(32'(req_o), 32'h0, "drive level");
    endtask : expect_res

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // ************************************************************
    // Clock and watchdog
    // ************************************************************
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    // Whole run needs some 300 cycles; allow over sixty times that
    initial begin
        #200000;
        n_fail++;
        close_out();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rows = '{
            '{mpra_pkg::MPRA_OP_TEST,    1'h0, 6'h04, 1},
            '{mpra_pkg::MPRA_OP_SET,     1'h0, 6'h01, 1},
            '{mpra_pkg::MPRA_OP_TEST,    1'h0, 6'h03, 1},
            '{mpra_pkg::MPRA_OP_RELEASE, 1'h0, 6'h00, 1},
            '{mpra_pkg::MPRA_OP_REQUEST, 1'h0, 6'h15, 8},
            '{mpra_pkg::MPRA_OP_RELEASE, 1'h0, 6'h00, 1},
            '{mpra_pkg::MPRA_OP_REQUEST, 1'h1, 6'h22, 1},
            '{mpra_pkg::MPRA_OP_TEST,    1'h1, 6'h02, 1},
            '{mpra_pkg::MPRA_OP_SET,     1'h1, 6'h01, 1},
            '{mpra_pkg::MPRA_OP_RELEASE, 1'h1, 6'h00, 1}
        };
        n_fail = 0;
        num_checks = 0;
        reset = 1'h1;
        cmd_valid = 1'h0;
        cmd = '0;
        upper_req = 1'h0;
        lower_req = 1'h0;
        slow = 1'h0;
        repeat (12) @(negedge core_clk);
        reset = 1'h0;
        // Table of plain commands; the pause lets the synchroniser fill
        foreach (rows[i]) begin
            lower_req = rows[i].low;
            repeat (6) @(negedge core_clk);
            run_cmd(rows[i].op, 16'h0000, 1'h0);
            expect_res(rows[i].exp, rows[i].lat);
            check(32'(res.op), 32'(rows[i].op), "result op");
        end
        // Accept passes through when idle, blocked while requesting
        check(32'(acc_out_n), 32'(acc_in_n), "accept pass");
        check(32'(acc_out_n), 32'h0, "accept low");
        run_cmd(mpra_pkg::MPRA_OP_SET, 16'h0000, 1'h0);
        check(32'(acc_out_n), 32'h1, "accept blocked");
        run_cmd(mpra_pkg::MPRA_OP_RELEASE, 16'h0000, 1'h0);
        lower_req = 1'h0;
        // Slow chain: short settle fails, longer settle succeeds
        // Long chain must first flush the accept left by the lower stage
        slow = 1'h1;
        repeat (30) @(negedge core_clk);
        run_cmd(mpra_pkg::MPRA_OP_REQUEST, 16'h0000, 1'h0);
        expect_res(6'h08, 8);
        repeat (40) @(negedge core_clk);
        run_cmd(mpra_pkg::MPRA_OP_REQUEST, 16'h0005, 1'h0);
        expect_res(6'h15, 43);
        run_cmd(mpra_pkg::MPRA_OP_RELEASE, 16'h0000, 1'h0);
        slow = 1'h0;
        repeat (40) @(negedge core_clk);
        // Higher stage requests in the same cycle: we lose the race
        run_cmd(mpra_pkg::MPRA_OP_REQUEST, 16'h0000, 1'h1);
        expect_res(6'h08, 8);
        upper_req = 1'h0;
        // Reset in mid-run drops a held request
        run_cmd(mpra_pkg::MPRA_OP_SET, 16'h0000, 1'h0);
        reset = 1'h1;
        repeat (12) @(negedge core_clk);
        reset = 1'h0;
        check(32'(req_oe), 32'h0, "reset drop");
        check(32'(cmd_ready), 32'h1, "reset ready");
        check(32'(res_valid), 32'h0, "reset result");
        close_out();
    end

endmodule : mpra_top_test
